// file: hw/sdpdr_top.sv
`timescale 1ns/1ps
`default_nettype none
module sdpdr_top (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // memory pins from the controller
    input wire logic CKE_I,
    input wire logic CS_N_I,
    input wire logic RAS_N_I,
    input wire logic CAS_N_I,
    input wire logic WE_N_I,
    input wire logic MEM_RESET_N_I,
    // core status on the same clock
    input wire logic BANK_OPEN_I,
    input wire logic OPS_BUSY_I,
    input wire logic DLL_LOCKED_I,
    // core control outputs
    output logic BUF_EN_O,
    output logic OUTPUT_EN_O,
    output logic TERM_EN_O,
    output logic ODT_ASYNC_O,
    output logic DLL_ON_O,
    output logic POWER_DOWN_O,
    output logic CMD_READY_O,
    output logic DLL_CMD_READY_O,
    output logic REFRESH_CLR_O,
    output logic CORE_RESET_O,
    // axi4-lite write
    input wire logic [3:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // axi4-lite read
    input wire logic [3:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    // pin synchronisers: stage a feeds stage b only
    logic [5:0] pin_a;
    logic [5:0] pin_b;
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            pin_a <= 6'h3F;
            pin_b <= 6'h3F;
        end else begin
            pin_a <= {MEM_RESET_N_I, WE_N_I, CAS_N_I, RAS_N_I, CS_N_I, CKE_I};
            pin_b <= pin_a;
        end
    end
    wire cke_s = pin_b[0];
    wire mem_rst_low = !pin_b[5];
    // deselect, or selected with ras, cas and we all high
    wire nop_des = pin_b[1] || (pin_b[4:2] == 3'b111);

    sdpdr_pkg::sdpdr_state_t state;
    sdpdr_pkg::sdpdr_state_t next_state;
    logic [12:0] mode0;
    logic [1:0] flags;
    logic [7:0] cpded_cnt;
    logic [7:0] xp_cnt;
    logic [7:0] xpdll_cnt;
    logic [7:0] odt_cnt;
    logic slow_exit;

    // every power-down flavour, the settle wait included, counts as power-down
    wire in_pd = (state == sdpdr_pkg::ST_ACT_PD) ||
                 (state == sdpdr_pkg::ST_PRE_FAST) ||
                 (state == sdpdr_pkg::ST_PRE_SLOW) ||
                 (state == sdpdr_pkg::ST_SETTLE);
    wire in_reset = (state == sdpdr_pkg::ST_RESET);
    wire in_idle = (state == sdpdr_pkg::ST_IDLE);
    wire in_slow = (state == sdpdr_pkg::ST_PRE_SLOW);
    wire fast_exit_sel = mode0[sdpdr_pkg::MODE0_FAST_EXIT_BIT];
    // precharge choice made only once in-progress work has drained
    wire settled = !OPS_BUSY_I;
    sdpdr_pkg::sdpdr_state_t pd_target;
    sdpdr_pkg::sdpdr_state_t pre_target;
    // an open bank always means active power-down, whatever the exit bit says
    assign pre_target = fast_exit_sel ? sdpdr_pkg::ST_PRE_FAST : sdpdr_pkg::ST_PRE_SLOW;
    assign pd_target = BANK_OPEN_I ? sdpdr_pkg::ST_ACT_PD : pre_target;
    wire enter_pd = in_idle && !mem_rst_low && !cke_s && nop_des;
    wire exit_pd = in_pd && !mem_rst_low && cke_s && nop_des;
    wire enter_rst = mem_rst_low && !in_reset;

    // power-down sequencing; reset pin overrides every state
    always_comb begin
        next_state = state;
        unique case (state)
            sdpdr_pkg::ST_IDLE: begin
                if (mem_rst_low) begin
                    next_state = sdpdr_pkg::ST_RESET;
                end else if (enter_pd) begin
                    next_state = settled ? pd_target : sdpdr_pkg::ST_SETTLE;
                end
            end
            sdpdr_pkg::ST_SETTLE: begin
                if (mem_rst_low) begin
                    next_state = sdpdr_pkg::ST_RESET;
                end else if (exit_pd) begin
                    next_state = sdpdr_pkg::ST_IDLE;
                end else if (settled) begin
                    next_state = pd_target;
                end
            end
            sdpdr_pkg::ST_ACT_PD, sdpdr_pkg::ST_PRE_FAST, sdpdr_pkg::ST_PRE_SLOW: begin
                if (mem_rst_low) begin
                    next_state = sdpdr_pkg::ST_RESET;
                end else if (exit_pd) begin
                    next_state = sdpdr_pkg::ST_IDLE;
                end
            end
            sdpdr_pkg::ST_RESET: begin
                if (!mem_rst_low) begin
                    next_state = sdpdr_pkg::ST_IDLE;
                end
            end
            default: begin
                // codes 6 and 7 are unused; fall back to the safe reset state
                next_state = sdpdr_pkg::ST_RESET;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            state <= sdpdr_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // remember whether the loop was off so the exit knows which delay applies
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I || in_reset) begin
            slow_exit <= 1'b0;
        end else if (in_slow) begin
            slow_exit <= 1'b1;
        end else if (in_pd && next_state == sdpdr_pkg::ST_PRE_SLOW) begin
            slow_exit <= 1'b1;
        end else if (enter_pd) begin
            slow_exit <= 1'b0;
        end
    end

    // buffer disable delay counted from entry; buffers stay on until it runs out
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            cpded_cnt <= 8'h00;
        end else if (enter_pd) begin
            cpded_cnt <= sdpdr_pkg::BUFFER_DISABLE_DELAY;
        end else if (cpded_cnt != 8'h00) begin
            cpded_cnt <= cpded_cnt - 8'h01;
        end
    end
    assign BUF_EN_O = !(in_pd && cpded_cnt == 8'h00) && !in_reset;

    // exit latency and locked loop delay run from the exit edge
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I || in_reset) begin
            xp_cnt <= 8'h00;
            xpdll_cnt <= 8'h00;
        end else if (exit_pd) begin
            xp_cnt <= sdpdr_pkg::EXIT_LATENCY;
            xpdll_cnt <= slow_exit ? sdpdr_pkg::LOCKED_LOOP_EXIT_DELAY : sdpdr_pkg::EXIT_LATENCY;
        end else begin
            if (xp_cnt != 8'h00) begin
                xp_cnt <= xp_cnt - 8'h01;
            end
            if (xpdll_cnt != 8'h00) begin
                xpdll_cnt <= xpdll_cnt - 8'h01;
            end
        end
    end
    assign CMD_READY_O = in_idle && (xp_cnt == 8'h00);
    assign DLL_CMD_READY_O = in_idle && (xpdll_cnt == 8'h00);

    // tail after a slow exit; both constants are small, so the 8-bit sum cannot wrap
    wire [7:0] odt_tail = 8'(sdpdr_pkg::TERMINATION_ASYNC_LEAD + sdpdr_pkg::LOCKED_LOOP_EXIT_DELAY);

    // termination is asynchronous for the whole slow-exit stay plus lead and loop delay after;
    // the lead before entry cannot be seen ahead, so it is covered from the entry edge
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I || in_reset) begin
            odt_cnt <= 8'h00;
        end else if (exit_pd && slow_exit) begin
            odt_cnt <= odt_tail;
        end else if (odt_cnt != 8'h00) begin
            odt_cnt <= odt_cnt - 8'h01;
        end
    end
    assign ODT_ASYNC_O = in_slow || (odt_cnt != 8'h00);

    // loop off in slow-exit precharge power-down and while in reset
    assign DLL_ON_O = !in_slow && !in_reset;
    assign POWER_DOWN_O = in_pd;
    assign OUTPUT_EN_O = !in_reset && !in_pd;
    assign TERM_EN_O = !in_reset;
    assign CORE_RESET_O = in_reset;
    // one-cycle pulse on the last reset cycle; counters outside watch it
    assign REFRESH_CLR_O = in_reset && (next_state == sdpdr_pkg::ST_IDLE);

    // axi4-lite slave: one write and one read at a time, answer one cycle after both halves
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;

    assign S_AXI_AWREADY_O = !aw_held && !bvalid;
    assign S_AXI_WREADY_O = !w_held && !bvalid;
    wire aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    wire w_take = S_AXI_WVALID_I && S_AXI_WREADY_O;
    wire have_aw = aw_held || aw_take;
    wire have_w = w_held || w_take;
    wire do_write = have_aw && have_w && !bvalid;
    wire [3:0] wr_addr = aw_held ? aw_addr : S_AXI_AWADDR_I;
    wire [31:0] wr_data = w_held ? w_data : S_AXI_WDATA_I;
    wire [3:0] wr_strb = w_held ? w_strb : S_AXI_WSTRB_I;
    wire wr_mode0 = do_write && (wr_addr == sdpdr_pkg::MODE0_OFFSET);
    wire wr_flags = do_write && (wr_addr == sdpdr_pkg::FLAGS_OFFSET) && wr_strb[0];
    wire wr_mapped = (wr_addr == sdpdr_pkg::MODE0_OFFSET) || (wr_addr == sdpdr_pkg::FLAGS_OFFSET);
    wire [31:0] byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [12:0] next_mode0 = (mode0 & ~byte_mask[12:0]) | (wr_data[12:0] & byte_mask[12:0]);

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr <= S_AXI_AWADDR_I;
            end
            if (w_take) begin
                w_data <= S_AXI_WDATA_I;
                w_strb <= S_AXI_WSTRB_I;
            end
            aw_held <= do_write ? 1'b0 : have_aw;
            w_held <= do_write ? 1'b0 : have_w;
        end
    end

    // write response
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            bvalid <= 1'b0;
            bresp <= sdpdr_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_mapped ? sdpdr_pkg::RESP_OKAY : sdpdr_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            bvalid <= 1'b0;
        end
    end
    assign S_AXI_BVALID_O = bvalid;
    assign S_AXI_BRESP_O = bresp;

    // mode register shadow; pin reset returns it to its reset value
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            mode0 <= sdpdr_pkg::MODE0_RESET;
        end else if (in_reset) begin
            mode0 <= sdpdr_pkg::MODE0_RESET;
        end else if (wr_mode0) begin
            mode0 <= next_mode0;
        end
    end

    // sticky flags, write one to clear; a setting event wins over the clear
    wire set_unknown = enter_rst;
    wire set_loop_reset = enter_pd && !DLL_LOCKED_I;
    wire [1:0] flag_set = {set_loop_reset, set_unknown};
    wire [1:0] flag_clr = wr_flags ? wr_data[1:0] : 2'b00;
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            flags <= 2'b00;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    // write recovery clocks used by the controller for entry after a write
    // raw field value; the controller side does the clock arithmetic
    wire [2:0] wr_recovery = mode0[sdpdr_pkg::MODE0_WR_LSB +: 3];

    // status word: 20 spare bits, 8 flags, 1 zero bit, 3 state bits
    wire [31:0] status_word = {20'h00000, in_pd, slow_exit, BUF_EN_O, ODT_ASYNC_O, DLL_ON_O,
                               DLL_CMD_READY_O, CMD_READY_O, CORE_RESET_O, 1'b0, state};
    // flags word
    wire [31:0] flags_word = {30'h00000000,
                              flags[sdpdr_pkg::FLAG_LOOP_RESET_BIT],
                              flags[sdpdr_pkg::FLAG_DATA_UNKNOWN_BIT]};
    wire rd_mode0 = (S_AXI_ARADDR_I == sdpdr_pkg::MODE0_OFFSET);
    wire rd_status = (S_AXI_ARADDR_I == sdpdr_pkg::STATUS_OFFSET);
    wire rd_flags = (S_AXI_ARADDR_I == sdpdr_pkg::FLAGS_OFFSET);
    wire rd_wrrec = (S_AXI_ARADDR_I == sdpdr_pkg::WRREC_OFFSET);
    wire rd_mapped = rd_mode0 || rd_status || rd_flags || rd_wrrec;
    wire [31:0] rd_word = rd_mode0 ? {19'h00000, mode0} :
                          rd_status ? status_word :
                          rd_flags ? flags_word :
                          rd_wrrec ? {29'h00000000, wr_recovery} : 32'h00000000;

    assign S_AXI_ARREADY_O = !rvalid;
    wire ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

    // read answer registered, held until taken
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            rvalid <= 1'b0;
            rresp <= sdpdr_pkg::RESP_OKAY;
            rdata <= 32'h00000000;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rresp <= rd_mapped ? sdpdr_pkg::RESP_OKAY : sdpdr_pkg::RESP_SLVERR;
            rdata <= rd_word;
        end else if (S_AXI_RREADY_I) begin
            rvalid <= 1'b0;
        end
    end
    assign S_AXI_RVALID_O = rvalid;
    assign S_AXI_RRESP_O = rresp;
    assign S_AXI_RDATA_O = rdata;
endmodule : sdpdr_top
`default_nettype wire

// file: common/sdpdr_pkg.sv
// How it works
// - power-down entered when clock enable samples low with a no-op or deselect
// - write recovery count taken from mode register 0 bits 11 to 9
// - on power-down entry all buffers off except clock, termination, enable, reset
// - open bank after settling gives active power-down, else precharge power-down
// - in precharge power-down mode bit 12 high keeps loop on, low turns off
// - reset falling during power-down leaves power-down into the reset state
// - exit when enable samples high with no-op; enable then held its pulse time
// - slow exit termination is asynchronous from lead before entry to lead+delay after; the code starts it at entry
// - low reset input is an asynchronous reset acting whenever it falls; the code takes it through a two-stage synchroniser
// - while reset low outputs off, termination off, internal state cleared
// - after reset refresh counters cleared and data unknown; controller reinitialises
package sdpdr_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // locked loop exit delay: greater of 10 clocks or 24 ns
    localparam int XPDLL_MIN_CK = 10;
    localparam int XPDLL_MIN_NS = 24;
    localparam int XPDLL_NS_CK = (XPDLL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] LOCKED_LOOP_EXIT_DELAY = 8'(XPDLL_MIN_CK > XPDLL_NS_CK ? XPDLL_MIN_CK : XPDLL_NS_CK);
    localparam logic [7:0] EXIT_LATENCY = 8'h03;
    localparam logic [7:0] BUFFER_DISABLE_DELAY = 8'h01;
    localparam logic [7:0] TERMINATION_ASYNC_LEAD = 8'h02;
    // register byte offsets
    localparam logic [3:0] MODE0_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] FLAGS_OFFSET = 4'h8;
    localparam logic [3:0] WRREC_OFFSET = 4'hC;
    localparam logic [12:0] MODE0_RESET = 13'h0000;
    localparam int MODE0_FAST_EXIT_BIT = 12;
    localparam int MODE0_WR_LSB = 9;
    localparam int FLAG_DATA_UNKNOWN_BIT = 0;
    localparam int FLAG_LOOP_RESET_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACT_PD = 3'b001,
        ST_PRE_FAST = 3'b010,
        ST_PRE_SLOW = 3'b011,
        ST_SETTLE = 3'b100,
        ST_RESET = 3'b101
    } sdpdr_state_t;
endpackage : sdpdr_pkg

// file: testbench/sdpdr_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sdpdr_top_sva (
    // clock, reset and pins
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic CKE_I,
    input wire logic CS_N_I,
    input wire logic RAS_N_I,
    input wire logic CAS_N_I,
    input wire logic WE_N_I,
    input wire logic MEM_RESET_N_I,
    input wire logic OPS_BUSY_I,
    // core control outputs
    input wire logic BUF_EN_O,
    input wire logic OUTPUT_EN_O,
    input wire logic TERM_EN_O,
    input wire logic ODT_ASYNC_O,
    input wire logic DLL_ON_O,
    input wire logic POWER_DOWN_O,
    input wire logic CMD_READY_O,
    input wire logic DLL_CMD_READY_O,
    input wire logic REFRESH_CLR_O,
    input wire logic CORE_RESET_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    // enable low with a no-op or deselect while the device runs normally
    wire logic lo_nop = !CKE_I && (CS_N_I || (RAS_N_I && CAS_N_I && WE_N_I));
    wire logic run = !POWER_DOWN_O && !CORE_RESET_O && MEM_RESET_N_I;
    sequence s_entry;
        (run && lo_nop) [*3];
    endsequence
    // after slow exit the loop-bound commands wait and termination stays async
    sequence s_slow_tail;
        (!DLL_CMD_READY_O && ODT_ASYNC_O) [*8];
    endsequence
    a_pd_entry: assert property (s_entry |-> ##[0:1] POWER_DOWN_O)
        else $error("power-down not entered");
    a_buf_off: assert property ($rose(POWER_DOWN_O) && !OPS_BUSY_I |-> !OUTPUT_EN_O ##[0:2] !BUF_EN_O)
        else $error("buffers still on in power-down");
    a_pd_hold: assert property ((POWER_DOWN_O && !CKE_I && MEM_RESET_N_I) [*3] |=> POWER_DOWN_O)
        else $error("power-down left with enable low");
    a_slow_async: assert property (POWER_DOWN_O && !DLL_ON_O |-> ODT_ASYNC_O)
        else $error("termination not async in slow power-down");
    a_slow_exit: assert property ($fell(POWER_DOWN_O) && !$past(DLL_ON_O) && !CORE_RESET_O
        |-> s_slow_tail ##[1:4] DLL_CMD_READY_O)
        else $error("loop exit delay wrong");
    a_exit_lat: assert property ($fell(POWER_DOWN_O) && !CORE_RESET_O |-> !CMD_READY_O ##[1:4] CMD_READY_O)
        else $error("exit latency wrong");
    a_reset_take: assert property ($fell(MEM_RESET_N_I) |-> ##[2:4] CORE_RESET_O && !POWER_DOWN_O)
        else $error("reset pin not taken");
    a_reset_off: assert property (CORE_RESET_O |-> !OUTPUT_EN_O && !TERM_EN_O && !DLL_ON_O)
        else $error("outputs live during reset");
    a_ref_clear: assert property (REFRESH_CLR_O |-> CORE_RESET_O ##1 !(CORE_RESET_O || REFRESH_CLR_O))
        else $error("refresh clear not on last reset cycle");
    a_ref_pulse: assert property ($fell(CORE_RESET_O) |-> $past(REFRESH_CLR_O))
        else $error("reset left without refresh clear");
endmodule : sdpdr_top_sva
`default_nettype wire

// file: testbench/sdpdr_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdpdr_ctl_model #(
    parameter int MIN_PD_CK = 6
) (
    // bench clock
    input wire logic clk_i,
    // command pins towards the memory
    output logic cke_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic reset_n_o
);
    int low_ck = 0;
    // idle as a no-op with the enable high so nothing is entered by accident
    initial {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, reset_n_o} = 6'h2F;
    // cycles with the enable low, kept for the minimum power-down hold
    always @(posedge clk_i) low_ck <= cke_o ? 0 : low_ck + 1;
    // drop the enable at the next clock with a no-op, or a deselect when desel is set
    task automatic pd_enter(input logic desel);
        @(posedge clk_i);
        {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} <= {1'b0, desel, 3'h7};
    endtask : pd_enter
    // raise the enable; a bad exit carries an activate the device must ignore
    task automatic pd_exit(input logic bad);
        while (!cke_o && low_ck < MIN_PD_CK) @(posedge clk_i);
        @(posedge clk_i);
        {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} <= {2'h2, ~bad, 2'h3};
    endtask : pd_exit
    // reset with the enable low, held past 100 ns at this clock
    task automatic reset_low;
        @(posedge clk_i);
        reset_n_o <= 1'b0;
        cke_o <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : reset_low
    // release, then start over with the enable high as at power-up
    task automatic reset_high;
        @(posedge clk_i);
        reset_n_o <= 1'b1;
        @(posedge clk_i);
        cke_o <= 1'b1;
    endtask : reset_high
endmodule : sdpdr_ctl_model
`default_nettype wire

// file: testbench/sdpdr_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module sdpdr_top_test;
    wire logic cke, cs_n, ras_n, cas_n, we_n, mem_rst_n;
    wire logic buf_en, out_en, term_en, odt_async, dll_on, pd, cmd_rdy, dll_rdy, ref_clr, core_rst;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    logic clk = 1'b0, rst_n = 1'b0, bank_open = 1'b0, ops_busy = 1'b0, dll_locked = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    int checks = 0, err_total = 0, cycles = 0, n;
    // 50 MHz clock
    always #10 clk = ~clk;
    sdpdr_ctl_model u_sdpdr_ctl_model (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
        .cas_n_o(cas_n), .we_n_o(we_n), .reset_n_o(mem_rst_n));
    sdpdr_top u_sdpdr_top (.CLOCK_I(clk), .RST_N_I(rst_n), .CKE_I(cke), .CS_N_I(cs_n), .RAS_N_I(ras_n),
        .CAS_N_I(cas_n), .WE_N_I(we_n), .MEM_RESET_N_I(mem_rst_n), .BANK_OPEN_I(bank_open),
        .OPS_BUSY_I(ops_busy), .DLL_LOCKED_I(dll_locked), .BUF_EN_O(buf_en), .OUTPUT_EN_O(out_en),
        .TERM_EN_O(term_en), .ODT_ASYNC_O(odt_async), .DLL_ON_O(dll_on), .POWER_DOWN_O(pd),
        .CMD_READY_O(cmd_rdy), .DLL_CMD_READY_O(dll_rdy), .REFRESH_CLR_O(ref_clr), .CORE_RESET_O(core_rst),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
    // write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
    endtask : axi_wr
    // read and compare the masked word
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        `CHK("rresp", er, rresp)
        `CHK("rdata", e, rdata & m)
    endtask : axi_rd
    // bounded wait for the power-down flag
    task automatic wait_pd(input logic v);
        n = 0;
        while (pd !== v && n < 40) begin
            @(posedge clk);
            n++;
        end
        `CHK("power_down", v, pd)
    endtask : wait_pd
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        axi_rd(sdpdr_pkg::MODE0_OFFSET, 32'h0, 32'h1FFF, sdpdr_pkg::RESP_OKAY);
        axi_rd(4'h2, 32'h0, 32'h0, sdpdr_pkg::RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            axi_wr(sdpdr_pkg::MODE0_OFFSET, 32'(i) << 9, sdpdr_pkg::RESP_OKAY);
            axi_rd(sdpdr_pkg::WRREC_OFFSET, 32'(i), 32'h7, sdpdr_pkg::RESP_OKAY);
        end
        $display("test write recovery done");
        // active, fast precharge, slow precharge with the loop unlocked
        for (int m = 0; m < 3; m++) begin
            bank_open <= (m == 0);
            dll_locked <= (m != 2);
            axi_wr(sdpdr_pkg::MODE0_OFFSET, (m == 1) ? 32'h1000 : 32'h0, sdpdr_pkg::RESP_OKAY);
            u_sdpdr_ctl_model.pd_enter(m[0]);
            wait_pd(1'b1);
            repeat (3) @(posedge clk);
            `CHK("buf_en", 1'b0, buf_en)
            `CHK("dll_on", m != 2, dll_on)
            `CHK("odt_async", m == 2, odt_async)
            axi_rd(sdpdr_pkg::STATUS_OFFSET, 32'(m + 1), 32'h7, sdpdr_pkg::RESP_OKAY);
            u_sdpdr_ctl_model.pd_exit(1'b1);
            repeat (3) @(posedge clk);
            `CHK("power_down", 1'b1, pd)
            u_sdpdr_ctl_model.pd_exit(1'b0);
            wait_pd(1'b0);
            n = 0;
            while (dll_rdy !== 1'b1 && n < 30) begin
                @(posedge clk);
                n++;
            end
            `CHK("loop_wait", 1'b1, (m == 2) ? n >= 8 : n <= 4)
            `CHK("cmd_ready", 1'b1, cmd_rdy)
            axi_rd(sdpdr_pkg::FLAGS_OFFSET, (m == 2) ? 32'h2 : 32'h0, 32'h2, sdpdr_pkg::RESP_OKAY);
            axi_wr(sdpdr_pkg::FLAGS_OFFSET, 32'h3, sdpdr_pkg::RESP_OKAY);
            $display("test power-down mode %0d done", m);
        end
        // entry while operations still run settles first
        dll_locked <= 1'b1;
        bank_open <= 1'b0;
        ops_busy <= 1'b1;
        u_sdpdr_ctl_model.pd_enter(1'b0);
        repeat (6) @(posedge clk);
        axi_rd(sdpdr_pkg::STATUS_OFFSET, 32'h4, 32'h7, sdpdr_pkg::RESP_OKAY);
        ops_busy <= 1'b0;
        repeat (4) @(posedge clk);
        axi_rd(sdpdr_pkg::STATUS_OFFSET, 32'h803, 32'h807, sdpdr_pkg::RESP_OKAY);
        $display("test settle done");
        // memory reset taken from slow power-down; mode set first so its clearing shows
        axi_wr(sdpdr_pkg::MODE0_OFFSET, 32'h1000, sdpdr_pkg::RESP_OKAY);
        u_sdpdr_ctl_model.reset_low();
        `CHK("core_reset", 1'b1, core_rst)
        `CHK("power_down", 1'b0, pd)
        `CHK("output_en", 1'b0, out_en)
        `CHK("term_en", 1'b0, term_en)
        u_sdpdr_ctl_model.reset_high();
        n = 0;
        while (ref_clr !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        `CHK("refresh_clear", 1'b1, ref_clr)
        axi_rd(sdpdr_pkg::FLAGS_OFFSET, 32'h1, 32'h1, sdpdr_pkg::RESP_OKAY);
        axi_rd(sdpdr_pkg::MODE0_OFFSET, 32'h0, 32'h1FFF, sdpdr_pkg::RESP_OKAY);
        $display("test memory reset done");
        print_verdict();
    end
endmodule : sdpdr_top_test
bind sdpdr_top sdpdr_top_sva u_sdpdr_top_sva (.*);
`default_nettype wire
